// ===== design/iacd_decoder.sv
/*
 * Auxiliary command decoder: turns auxiliary mode register writes into
 * local messages, the continuous listen mode and the IFC and REN levels.
 * Assumes all inputs but rst_b are synchronous to clk and that function state
 * inputs come from the interface state machines of the same chip.
 */
`default_nettype none

module iacd_decoder (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic aux_wr,
    input wire iacd_pkg::iacd_aux_word_t aux_mode_register,
    input wire iacd_pkg::iacd_fn_state_t fn_state,
    input wire logic anrs_enter,
    input wire logic end_received,
    input wire logic byte_received,
    input wire logic data_in_clear,
    input wire logic cfg_wr,
    input wire logic cfg_sc_value,
    output iacd_pkg::iacd_msg_pulse_t msg_pulse,
    output logic continuous_mode,
    output logic rfd_holdoff,
    output logic data_in_flag,
    output logic rpp,
    output logic rsc,
    output logic ifc_line,
    output logic ren_line,
    output logic system_controller_bit
);

    logic rst_sync_b;

    iacd_reset_sync u_reset_sync (
        .clk(clk),
        .rst_b(rst_b),
        .rst_sync_b(rst_sync_b)
    );

    logic is_cmd;
    logic [4:0] code;
    logic value_bit;
    logic cmd_listen;
    logic cmd_listen_cont;
    logic cmd_unlisten;
    logic cmd_exec_pp;
    logic cmd_disable_sc;
    logic cmd_ifc;
    logic cmd_ren;

    // Only the auxiliary command control code reaches the decoder.
    always_comb begin
        is_cmd = aux_wr &&
            (aux_mode_register.control_code == iacd_pkg::CTL_AUX_CMD);
        code = aux_mode_register.command_code_field;
        value_bit = code[iacd_pkg::VALUE_BIT_POS];
        cmd_listen = is_cmd && (code == iacd_pkg::CMD_LISTEN);
        cmd_listen_cont = is_cmd && (code == iacd_pkg::CMD_LISTEN_CONT);
        cmd_unlisten = is_cmd && (code == iacd_pkg::CMD_LOCAL_UNLISTEN);
        cmd_exec_pp = is_cmd && (code == iacd_pkg::CMD_EXEC_PP);
        cmd_disable_sc = is_cmd && (code == iacd_pkg::CMD_DISABLE_SC);
        cmd_ifc = is_cmd && (code[4:3] == iacd_pkg::CMD_LINE_HIGH
            || code[4:3] == {iacd_pkg::CMD_LINE_HIGH[1], 1'b1})
            && (code[2] == 1'b1)
            && (code[1:0] == iacd_pkg::CMD_IFC_LOW);
        cmd_ren = is_cmd && (code[4] == 1'b1)
            && (code[2] == 1'b1)
            && (code[1:0] == iacd_pkg::CMD_REN_LOW);
    end

    iacd_pkg::iacd_listen_mode_t mode;
    iacd_pkg::iacd_listen_mode_t next_mode;
    iacd_pkg::iacd_msg_pulse_t next_msg_pulse;
    logic next_continuous_mode;
    logic next_rfd_holdoff;

    // Listen mode machine and the one-cycle listener messages.
    always_comb begin
        next_mode = mode;
        next_msg_pulse = '0;
        next_msg_pulse.ltn = cmd_listen || cmd_listen_cont;
        next_msg_pulse.lun = cmd_unlisten;
        case (mode)
            iacd_pkg::IACD_NORMAL: begin
                if (cmd_listen_cont) begin
                    next_mode = iacd_pkg::IACD_CONT;
                end
            end
            iacd_pkg::IACD_CONT: begin
                if (cmd_listen_cont) begin
                    next_mode = iacd_pkg::IACD_CONT;
                end else if (cmd_listen || fn_state.in_lids) begin
                    next_mode = iacd_pkg::IACD_NORMAL;
                end else if (end_received) begin
                    next_mode = iacd_pkg::IACD_HOLDOFF;
                end else if (anrs_enter) begin
                    next_msg_pulse.rdy = 1'b1;
                end
            end
            iacd_pkg::IACD_HOLDOFF: begin
                // The holdoff lasts until continuous mode is released or listen continuous is written again.
                if (cmd_listen_cont) begin
                    next_mode = iacd_pkg::IACD_CONT;
                end else if (cmd_listen || fn_state.in_lids) begin
                    next_mode = iacd_pkg::IACD_NORMAL;
                end
            end
            default: begin
                next_mode = iacd_pkg::IACD_NORMAL;
            end
        endcase
        next_continuous_mode = (next_mode != iacd_pkg::IACD_NORMAL);
        next_rfd_holdoff = (next_mode == iacd_pkg::IACD_HOLDOFF);
    end

    always_ff @(posedge clk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            mode <= iacd_pkg::IACD_NORMAL;
            msg_pulse <= '0;
            continuous_mode <= iacd_pkg::RST_MSG;
            rfd_holdoff <= iacd_pkg::RST_MSG;
        end else begin
            mode <= next_mode;
            msg_pulse <= next_msg_pulse;
            continuous_mode <= next_continuous_mode;
            rfd_holdoff <= next_rfd_holdoff;
        end
    end

    logic next_data_in_flag;

    // A byte arriving in normal mode in the cycle of a clear still sets the flag.
    always_comb begin
        next_data_in_flag = data_in_flag;
        if (data_in_clear) begin
            next_data_in_flag = 1'b0;
        end
        if (byte_received && (mode == iacd_pkg::IACD_NORMAL)) begin
            next_data_in_flag = 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            data_in_flag <= iacd_pkg::RST_MSG;
        end else begin
            data_in_flag <= next_data_in_flag;
        end
    end

    logic next_rpp;

    // The hold on rpp is not gated against gts; software keeps them apart.
    always_comb begin
        next_rpp = rpp;
        if (fn_state.in_cpps || fn_state.in_cids) begin
            next_rpp = 1'b0;
        end
        if (cmd_exec_pp) begin
            next_rpp = 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            rpp <= iacd_pkg::RST_MSG;
        end else begin
            rpp <= next_rpp;
        end
    end

    logic next_rsc;
    logic next_ifc_line;
    logic next_ren_line;
    logic next_system_controller_bit;

    // Line commands are not gated by the controller bit; software checks
    // it first and also times the minimum IFC and REN intervals itself.
    always_comb begin
        next_rsc = rsc;
        next_ifc_line = ifc_line;
        next_ren_line = ren_line;
        next_system_controller_bit = system_controller_bit;
        if (cfg_wr) begin
            next_system_controller_bit = cfg_sc_value;
        end
        if (cmd_ifc) begin
            next_rsc = 1'b1;
            next_ifc_line = value_bit;
        end
        if (cmd_ren) begin
            next_rsc = 1'b1;
            next_ren_line = value_bit;
        end
        if (cmd_disable_sc) begin
            next_rsc = 1'b0;
            next_system_controller_bit = 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            rsc <= iacd_pkg::RST_MSG;
            ifc_line <= iacd_pkg::RST_LINE;
            ren_line <= iacd_pkg::RST_LINE;
            system_controller_bit <= iacd_pkg::RST_SC_BIT;
        end else begin
            rsc <= next_rsc;
            ifc_line <= next_ifc_line;
            ren_line <= next_ren_line;
            system_controller_bit <= next_system_controller_bit;
        end
    end

endmodule

`default_nettype wire

// ===== design/iacd_reset_sync.sv
/*
 * Reset release synchroniser: asynchronous assertion, two-stage release.
 * Assumes rst_b is active low and may change at any time.
 */
`default_nettype none

module iacd_reset_sync (
    input wire logic clk,
    input wire logic rst_b,
    output logic rst_sync_b
);

    logic stage_one;

    // Only the second stage reads the first, so no logic sees metastability.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            stage_one <= 1'b0;
            rst_sync_b <= 1'b0;
        end else begin
            stage_one <= 1'b1;
            rst_sync_b <= stage_one;
        end
    end

endmodule

`default_nettype wire

// ===== shared/iacd_pkg.sv
/*
 * Constants and carrier types of the auxiliary command decoder.
 * Assumes a 20 MHz clock and an 8-bit auxiliary mode register word.
 */
`default_nettype none

package iacd_pkg;

    localparam int CLK_HZ = 20_000_000;

    // Control code that routes the low field to the command decoder.
    localparam logic [2:0] CTL_AUX_CMD = 3'h0;

    localparam logic [4:0] CMD_LISTEN = 5'h13;
    localparam logic [4:0] CMD_LISTEN_CONT = 5'h1b;
    localparam logic [4:0] CMD_LOCAL_UNLISTEN = 5'h1c;
    localparam logic [4:0] CMD_EXEC_PP = 5'h1d;
    localparam logic [4:0] CMD_DISABLE_SC = 5'h14;

    // Set and clear forms share the low bits; bit 3 carries the value.
    localparam logic [1:0] CMD_LINE_HIGH = 2'h2;
    localparam logic [1:0] CMD_IFC_LOW = 2'h2;
    localparam logic [1:0] CMD_REN_LOW = 2'h3;
    localparam int VALUE_BIT_POS = 3;

    localparam logic RST_SC_BIT = 1'b0;
    localparam logic RST_LINE = 1'b0;
    localparam logic RST_MSG = 1'b0;

    typedef struct packed {
        logic [2:0] control_code;
        logic [4:0] command_code_field;
    } iacd_aux_word_t;

    typedef struct packed {
        logic in_lids;
        logic in_cpps;
        logic in_cids;
    } iacd_fn_state_t;

    typedef struct packed {
        logic ltn;
        logic lun;
        logic rdy;
    } iacd_msg_pulse_t;

    typedef enum logic [1:0] {
        IACD_NORMAL,
        IACD_CONT,
        IACD_HOLDOFF
    } iacd_listen_mode_t;

endpackage

`default_nettype wire

// ===== testbench/iacd_bus_model.sv
/* Bus state machines beside the decoder: function states and acceptor
   events, registered from a request word of the bench. */
`default_nettype none
module iacd_bus_model (
    input wire logic clk,
    input wire logic [5:0] req,
    output iacd_pkg::iacd_fn_state_t fn_state,
    output logic anrs_enter,
    output logic end_received,
    output logic byte_received
);
    timeunit 1ns;
    timeprecision 1ns;
    // Idle request gives idle levels, so no stale event lingers.
    always_ff @(posedge clk) begin
        {fn_state, anrs_enter, end_received, byte_received} <= req;
    end
endmodule
`default_nettype wire

// ===== testbench/iacd_decoder_props.sv
/* Port checker of the auxiliary command decoder.
   Assumes it is bound to iacd_decoder and sees only its ports. */
`default_nettype none
module iacd_decoder_props (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic aux_wr,
    input wire iacd_pkg::iacd_aux_word_t aux_mode_register,
    input wire iacd_pkg::iacd_fn_state_t fn_state,
    input wire logic anrs_enter,
    input wire logic end_received,
    input wire logic byte_received,
    input wire iacd_pkg::iacd_msg_pulse_t msg_pulse,
    input wire logic continuous_mode,
    input wire logic rfd_holdoff,
    input wire logic data_in_flag,
    input wire logic rpp,
    input wire logic rsc,
    input wire logic ifc_line,
    input wire logic ren_line,
    input wire logic system_controller_bit
);
    timeunit 1ns;
    timeprecision 1ns;
    wire logic [4:0] code = aux_mode_register.command_code_field;
    wire logic go = aux_wr && aux_mode_register.control_code == 3'h0;
    wire logic calm = !aux_wr && !fn_state.in_lids;
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    sequence s_one_lun;
        msg_pulse.lun ##1 !msg_pulse.lun;
    endsequence
    a_cont_enter: assert property (
        go && code == 5'h1b |=> msg_pulse.ltn && continuous_mode)
        else $error("continuous listen not entered");
    a_rdy_issue: assert property (
        anrs_enter && continuous_mode && !rfd_holdoff && !end_received
        && calm |=> msg_pulse.rdy) else $error("rdy missing");
    a_rdy_cause: assert property (msg_pulse.rdy |->
        $past(anrs_enter) && $past(continuous_mode) && !$past(rfd_holdoff))
        else $error("rdy without cause");
    a_end_holdoff: assert property (
        continuous_mode && end_received && calm |=> rfd_holdoff)
        else $error("holdoff not entered");
    a_no_data_flag: assert property (
        continuous_mode && byte_received && !data_in_flag && calm
        |=> !data_in_flag) else $error("flag set in continuous mode");
    a_lids_exit: assert property (
        fn_state.in_lids && !aux_wr |=> !continuous_mode && !rfd_holdoff)
        else $error("continuous mode kept in idle");
    a_lun_pulse: assert property (
        go && code == 5'h1c ##1 !(go && code == 5'h1c) |-> s_one_lun)
        else $error("lun not one pulse");
    a_rpp_clear: assert property (
        (fn_state.in_cpps || fn_state.in_cids) && !go |=> !rpp)
        else $error("rpp not cleared");
    a_line_level: assert property (
        go && code[4] && code[2:1] == 2'h3 |=> rsc
        && ($past(code[0]) ? ren_line : ifc_line) == $past(code[3]))
        else $error("line wrong");
    a_sc_disable: assert property (
        go && code == 5'h14 |=> !rsc && !system_controller_bit)
        else $error("system control not disabled");
    a_plain_listen: assert property (
        go && code == 5'h13 |=> msg_pulse.ltn && !continuous_mode)
        else $error("plain listen wrong");
endmodule
bind iacd_decoder iacd_decoder_props props (.clk, .rst_b, .aux_wr,
    .aux_mode_register, .fn_state, .anrs_enter, .end_received,
    .byte_received, .msg_pulse, .continuous_mode, .rfd_holdoff,
    .data_in_flag, .rpp, .rsc, .ifc_line, .ren_line, .system_controller_bit);
`default_nettype wire

// ===== testbench/iacd_decoder_tb_top.sv
/* Self-checking bench of the auxiliary command decoder.
   Assumes the decoder, its package and the bus model are compiled. */
`default_nettype none
module iacd_decoder_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk, rst_b, aux_wr, data_in_clear, cfg_wr, cfg_sc_value;
    iacd_pkg::iacd_aux_word_t aux_word;
    iacd_pkg::iacd_fn_state_t fn_state;
    iacd_pkg::iacd_msg_pulse_t msg_pulse;
    logic anrs_enter, end_received, byte_received, continuous_mode;
    logic rfd_holdoff, data_in_flag, rpp, rsc, ifc_line, ren_line, sc_bit;
    logic [5:0] req;
    logic [4:0] codes[4] = '{5'h1e, 5'h1f, 5'h16, 5'h17};
    logic [7:0] lines[4] = '{8'h06, 8'h07, 8'h05, 8'h04};
    int failures, n_checks;
    iacd_decoder uut (.clk(clk), .rst_b(rst_b), .aux_wr(aux_wr),
        .aux_mode_register(aux_word), .fn_state(fn_state),
        .anrs_enter(anrs_enter), .end_received(end_received),
        .byte_received(byte_received), .data_in_clear(data_in_clear),
        .cfg_wr(cfg_wr), .cfg_sc_value(cfg_sc_value), .msg_pulse(msg_pulse),
        .continuous_mode(continuous_mode), .rfd_holdoff(rfd_holdoff),
        .data_in_flag(data_in_flag), .rpp(rpp), .rsc(rsc),
        .ifc_line(ifc_line), .ren_line(ren_line),
        .system_controller_bit(sc_bit));
    iacd_bus_model bus (.clk(clk), .req(req), .fn_state(fn_state),
        .anrs_enter(anrs_enter), .end_received(end_received),
        .byte_received(byte_received));
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            failures++;
            $display("ERROR %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #5;
    endtask
    task automatic cmd(input logic [2:0] cc, input logic [4:0] code);
        aux_word = {cc, code};
        aux_wr = 1'b1;
        step(1);
        aux_wr = 1'b0;
    endtask
    // Bits: idle, poll, controller idle, not ready, end, byte.
    task automatic ev(input logic [5:0] r);
        req = r;
        step(1);
        req = 6'h00;
        step(1);
    endtask
    task automatic complete_run;
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    initial begin
        repeat (100000) @(posedge clk);
        failures++;
        complete_run();
    end
    initial begin
        {rst_b, aux_wr, data_in_clear, cfg_wr, cfg_sc_value} = 5'h00;
        aux_word = 8'h00;
        req = 6'h00;
        step(20);
        rst_b = 1'b1;
        step(3);
        chk(8'({msg_pulse, continuous_mode, rfd_holdoff, rpp, rsc}), 8'h00);
        chk(8'({data_in_flag, ifc_line, ren_line, sc_bit}), 8'h00);
        $display("test reset done");
        cmd(3'h0, 5'h1b);
        chk(8'({msg_pulse.ltn, continuous_mode}), 8'h03);
        step(1);
        chk(8'(msg_pulse.ltn), 8'h00);
        ev(6'h04);
        chk(8'(msg_pulse.rdy), 8'h01);
        ev(6'h01);
        chk(8'(data_in_flag), 8'h00);
        ev(6'h02);
        chk(8'({rfd_holdoff, continuous_mode}), 8'h03);
        ev(6'h04);
        chk(8'(msg_pulse.rdy), 8'h00);
        ev(6'h20);
        chk(8'({rfd_holdoff, continuous_mode}), 8'h00);
        $display("test continuous done");
        cmd(3'h0, 5'h1b);
        step(1);
        cmd(3'h0, 5'h13);
        chk(8'({msg_pulse.ltn, continuous_mode}), 8'h02);
        ev(6'h04);
        chk(8'(msg_pulse.rdy), 8'h00);
        ev(6'h01);
        chk(8'(data_in_flag), 8'h01);
        data_in_clear = 1'b1;
        step(1);
        data_in_clear = 1'b0;
        chk(8'(data_in_flag), 8'h00);
        $display("test listen done");
        cmd(3'h1, 5'h1c);
        chk(8'(msg_pulse.lun), 8'h00);
        step(1);
        cmd(3'h0, 5'h1c);
        chk(8'(msg_pulse.lun), 8'h01);
        step(1);
        chk(8'(msg_pulse.lun), 8'h00);
        cmd(3'h0, 5'h1d);
        step(5);
        chk(8'(rpp), 8'h01);
        ev(6'h10);
        chk(8'(rpp), 8'h00);
        cmd(3'h0, 5'h1d);
        ev(6'h08);
        chk(8'(rpp), 8'h00);
        $display("test messages done");
        cfg_sc_value = 1'b1;
        cfg_wr = 1'b1;
        step(1);
        cfg_wr = 1'b0;
        chk(8'(sc_bit), 8'h01);
        for (int i = 0; i < 4; i++) begin
            step(2000);
            cmd(3'h0, codes[i]);
            chk(8'({rsc, ifc_line, ren_line}), lines[i]);
        end
        step(1);
        cmd(3'h0, 5'h14);
        chk(8'({rsc, sc_bit}), 8'h00);
        $display("test system control done");
        complete_run();
    end
endmodule
`default_nettype wire
